/* pkg/swing_pkg.sv */
// constants for the swing frequency, length and count block
// assumes a 40 MHz mclk and frequencies in 0.01 Hz units
package swing_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  // swing cycle period in 0.1 s units
  localparam int unsigned PERIOD_TENTH_S   = 10;
  localparam logic [14:0] PERIOD_RST       = 15'h64;
  localparam logic [14:0] PERIOD_MIN       = 15'h1;
  localparam logic [14:0] PERIOD_MAX       = 15'h7530;
  // percentages in 0.1 % units
  localparam logic [9:0]  PCT_FULL         = 10'h3E8;
  localparam logic [9:0]  SWING_PCT_RST    = 10'h0;
  localparam logic [9:0]  JUMP_PCT_RST     = 10'h0;
  localparam logic [9:0]  JUMP_PCT_MAX     = 10'h1F4;
  localparam logic [9:0]  RISE_COEF_RST    = 10'h1F4;
  localparam logic [9:0]  RISE_COEF_MIN    = 10'h1;
  localparam logic        BASE_SEL_RST     = 1'b0;
  // length and count settings
  localparam logic [15:0] TARGET_LEN_RST   = 16'h3E8;
  localparam logic [15:0] PPM_RST          = 16'h3E8; // 0.1 pulse units
  localparam logic [15:0] COUNT_TARGET_RST = 16'h3E8;
  // step rate of the triangle phase: 1000 steps per 0.1 s unit
  localparam int unsigned PHASE_STEPS      = 1000;
  localparam int unsigned STEP_HZ          = PHASE_STEPS * PERIOD_TENTH_S;
  localparam int unsigned STEP_DIV         = CLK_HZ / STEP_HZ;
endpackage

/* rtl/swing_freq_length_counter.sv */
// swing frequency generator, length measurement and pulse counter
// assumes settings held stable by software, pulses from pins on mclk
// Functional notes
// - output swings about the centre frequency
// - zero amplitude percentage gives plain centre
// - base select: centre or maximum frequency
// - amplitude is reference times amplitude percentage
// - jump is amplitude times jump percentage
// - clamp output between upper and lower limits
// - one swing cycle lasts programmed period
// - rise time is period times coefficient
// - length equals pulses divided by pulses-per-metre
// - length above target asserts length-reached output
// - length reset input clears accumulated length
// - length pulses taken on high-speed input
// - count pulses taken on count input
// - final target reached: flag and stop counting
// - intermediate target flags, counting continues
module swing_freq_length_counter
  import swing_pkg::*;
#(
  parameter int unsigned STEP_DIV_P = STEP_DIV
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // swing settings, frequencies in 0.01 Hz
  input  wire logic [15:0] centre_frequency_source,
  input  wire logic [15:0] max_output_frequency,
  input  wire logic [15:0] upper_freq_limit,
  input  wire logic [15:0] lower_freq_limit,
  input  wire logic        swing_base_select,
  input  wire logic [9:0]  swing_amplitude_pct,
  input  wire logic [9:0]  jump_amplitude_pct,
  input  wire logic [14:0] swing_cycle_period,
  input  wire logic [9:0]  rise_time_coefficient,
  // length and count settings
  input  wire logic [15:0] target_length,
  input  wire logic [15:0] pulses_per_metre,
  input  wire logic [15:0] final_count_target,
  input  wire logic [15:0] intermediate_count_target,
  // digital input terminals
  input  wire logic        high_speed_pulse_input,
  input  wire logic        count_pulse_input,
  input  wire logic        length_reset_input,
  // results
  output logic [15:0]      output_frequency,
  output logic [15:0]      actual_swing_amplitude,
  output logic [15:0]      measured_length,
  output logic [15:0]      count_value,
  output logic             length_reached,
  output logic             final_count_reached,
  output logic             intermediate_count_reached
);

  typedef enum logic {RISING, FALLING} ramp_e;

  // scale a value by a 0.1 % setting
  function automatic logic [15:0] scale_pct(input logic [15:0] v,
                                            input logic [9:0]  p);
    logic [25:0] prod;
    prod = v * p;
    scale_pct = 16'(prod / 26'(PCT_FULL));
  endfunction

  // three-stage pin synchroniser, agreement of stages 2 and 3
  logic [2:0] len_s_q, cnt_s_q, rst_s_q;
  logic       len_lvl_q, cnt_lvl_q, rst_lvl_q;
  logic       len_rise, cnt_rise;

  always_ff @(posedge mclk) begin
    len_s_q <= {len_s_q[1:0], high_speed_pulse_input};
    cnt_s_q <= {cnt_s_q[1:0], count_pulse_input};
    rst_s_q <= {rst_s_q[1:0], length_reset_input};
    if (!rst_n) begin
      len_lvl_q <= 1'b0;
      cnt_lvl_q <= 1'b0;
      rst_lvl_q <= 1'b0;
    end else begin
      if (len_s_q[1] == len_s_q[2]) len_lvl_q <= len_s_q[2];
      if (cnt_s_q[1] == cnt_s_q[2]) cnt_lvl_q <= cnt_s_q[2];
      if (rst_s_q[1] == rst_s_q[2]) rst_lvl_q <= rst_s_q[2];
    end
  end

  assign len_rise = (len_s_q[1] == len_s_q[2]) && len_s_q[2] && !len_lvl_q;
  assign cnt_rise = (cnt_s_q[1] == cnt_s_q[2]) && cnt_s_q[2] && !cnt_lvl_q;

  // step-rate divider
  logic [15:0] div_q, div_d;
  logic        step;
  assign step = (div_q == 16'(STEP_DIV_P - 1));
  always_comb begin
    div_d = step ? 16'h0000 : div_q + 16'h0001;
  end

  // triangle phase: rise_steps up then fall_steps down
  logic [24:0] period_steps, rise_steps, fall_steps;
  logic [24:0] ph_q, ph_d;
  ramp_e       dir_q, dir_d;
  logic [14:0] per_c;
  logic [9:0]  coef_c;
  logic [34:0] rise_full;

  always_comb begin
    per_c = (swing_cycle_period < PERIOD_MIN) ? PERIOD_MIN :
            (swing_cycle_period > PERIOD_MAX) ? PERIOD_MAX :
            swing_cycle_period;
    coef_c = (rise_time_coefficient < RISE_COEF_MIN) ? RISE_COEF_MIN :
             (rise_time_coefficient > PCT_FULL) ? PCT_FULL :
             rise_time_coefficient;
    period_steps = 25'(per_c * PHASE_STEPS);
    rise_full    = 35'(period_steps) * 35'(coef_c);
    rise_steps   = 25'(rise_full / 35'(PCT_FULL));
    if (rise_steps == 25'h0) rise_steps = 25'h1;
    fall_steps   = period_steps - rise_steps;
    ph_d  = ph_q;
    dir_d = dir_q;
    if (step) begin
      unique case (dir_q)
        RISING: begin
          if (ph_q + 25'h1 >= rise_steps) begin
            ph_d  = 25'h0;
            dir_d = (fall_steps == 25'h0) ? RISING : FALLING;
          end else begin
            ph_d = ph_q + 25'h1;
          end
        end
        FALLING: begin
          if (ph_q + 25'h1 >= fall_steps) begin
            ph_d  = 25'h0;
            dir_d = RISING;
          end else begin
            ph_d = ph_q + 25'h1;
          end
        end
      endcase
    end
  end

  // frequency computation
  logic [15:0] ref_f, amp, jump;
  logic [41:0] frac_num;
  logic [16:0] span, tri_off;
  logic [17:0] f_raw;
  logic [15:0] freq_d;
  logic [9:0]  jpct_c;

  always_comb begin
    ref_f  = swing_base_select ? max_output_frequency
                               : centre_frequency_source;
    amp    = (swing_amplitude_pct > PCT_FULL) ? ref_f
             : scale_pct(ref_f, swing_amplitude_pct);
    jpct_c = (jump_amplitude_pct > JUMP_PCT_MAX) ? JUMP_PCT_MAX
             : jump_amplitude_pct;
    jump   = scale_pct(amp, jpct_c);
    // ramp spans 2*amp-jump, each turnaround steps back by jump
    span = {amp, 1'b0} - 17'(jump);
    if (dir_q == RISING) begin
      frac_num = 42'(ph_q) * 42'(span);
      tri_off  = 17'(jump) + 17'(frac_num / 42'(rise_steps));
    end else begin
      frac_num = 42'(fall_steps - ph_q) * 42'(span);
      tri_off  = 17'(frac_num / 42'((fall_steps == 25'h0) ? 25'h1
                                                         : fall_steps));
    end
    // rises from centre-amp+jump, falls from centre+amp-jump
    f_raw = 18'(centre_frequency_source) - 18'(amp) + 18'(tri_off);
    if (amp == 16'h0000) f_raw = 18'(centre_frequency_source);
    if ($signed(f_raw) > $signed({2'b00, upper_freq_limit}))
      freq_d = upper_freq_limit;
    else if (f_raw[17] || f_raw < 18'(lower_freq_limit))
      freq_d = lower_freq_limit;
    else
      freq_d = f_raw[15:0];
  end

  // length measurement: pulses*10 / (pulses_per_metre in 0.1 units)
  logic [31:0] len_pulses_q, len_pulses_d;
  logic [15:0] len_d;
  logic [35:0] len_calc;

  always_comb begin
    len_pulses_d = len_pulses_q;
    if (rst_lvl_q) len_pulses_d = 32'h0;
    else if (len_rise && len_pulses_q != 32'hFFFF_FFFF)
      len_pulses_d = len_pulses_q + 32'h1;
    len_calc = (36'(len_pulses_q) * 36'hA)
               / 36'((pulses_per_metre == 16'h0) ? 16'h1
                                                 : pulses_per_metre);
    len_d = (len_calc > 36'h0FFFF) ? 16'hFFFF : len_calc[15:0];
  end

  // counter
  logic [15:0] cnt_q, cnt_d;
  logic        fin_d, mid_d, lreach_d;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_rise && !final_count_reached) cnt_d = cnt_q + 16'h1;
    fin_d = final_count_reached || (cnt_d >= final_count_target);
    mid_d = intermediate_count_reached
            || (cnt_d >= intermediate_count_target);
    lreach_d = (len_d > target_length);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q                      <= 16'h0000;
      ph_q                       <= 25'h0;
      dir_q                      <= RISING;
      len_pulses_q               <= 32'h0;
      cnt_q                      <= 16'h0000;
      output_frequency           <= 16'h0000;
      actual_swing_amplitude     <= 16'h0000;
      measured_length            <= 16'h0000;
      count_value                <= 16'h0000;
      length_reached             <= 1'b0;
      final_count_reached        <= 1'b0;
      intermediate_count_reached <= 1'b0;
    end else begin
      div_q                      <= div_d;
      ph_q                       <= ph_d;
      dir_q                      <= dir_d;
      len_pulses_q               <= len_pulses_d;
      cnt_q                      <= cnt_d;
      output_frequency           <= freq_d;
      actual_swing_amplitude     <= amp;
      measured_length            <= len_d;
      count_value                <= cnt_d;
      length_reached             <= lreach_d;
      final_count_reached        <= fin_d;
      intermediate_count_reached <= mid_d;
    end
  end

endmodule

/* tb/swing_freq_length_counter_properties.sv */
// assertions on the swing, length and count outputs
// bound into swing_freq_length_counter, sees only its ports
module swing_freq_length_counter_chk (
  // clock, reset and length reset pin
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        length_reset_input,
  // settings
  input wire logic [9:0]  swing_amplitude_pct,
  input wire logic [15:0] centre_frequency_source,
  input wire logic [15:0] upper_freq_limit,
  input wire logic [15:0] lower_freq_limit,
  input wire logic [15:0] target_length,
  input wire logic [15:0] final_count_target,
  input wire logic [15:0] intermediate_count_target,
  // results
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] measured_length,
  input wire logic [15:0] count_value,
  input wire logic        length_reached,
  input wire logic        final_count_reached,
  input wire logic        intermediate_count_reached
);
  logic plain;
  assign plain = swing_amplitude_pct == 10'h0
    && centre_frequency_source <= upper_freq_limit
    && centre_frequency_source >= lower_freq_limit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_plain_centre: assert property (
    (plain && $stable(centre_frequency_source))[*4] |=>
    output_frequency == centre_frequency_source) else $error("not centre");
  a_upper_clamp: assert property ($stable(upper_freq_limit)[*3] |->
    output_frequency <= upper_freq_limit) else $error("above upper");
  a_lower_clamp: assert property ($stable(lower_freq_limit)[*4] |->
    output_frequency >= lower_freq_limit) else $error("below lower");
  a_length_above: assert property (
    $stable(measured_length) && $stable(target_length) |->
    length_reached == (measured_length > target_length))
    else $error("length flag wrong");
  a_length_clear: assert property (length_reset_input[*6] |=>
    measured_length == 16'h0) else $error("length not cleared");
  a_final_flag: assert property (count_value >= final_count_target |->
    ##[0:1] final_count_reached) else $error("final flag missing");
  a_count_stop: assert property (final_count_reached |=>
    $stable(count_value)) else $error("count moved after final");
  a_mid_flag: assert property (
    count_value >= intermediate_count_target |->
    ##[0:1] intermediate_count_reached) else $error("mid flag missing");
  a_reset_zero: assert property (disable iff (1'b0) !rst_n |=>
    count_value == 16'h0 && measured_length == 16'h0 && !length_reached
    && !final_count_reached && !intermediate_count_reached)
    else $error("not cleared by reset");
  c_final: cover property ($rose(final_count_reached));
  c_mid: cover property ($rose(intermediate_count_reached));
  c_len: cover property ($rose(length_reached));
endmodule

bind swing_freq_length_counter swing_freq_length_counter_chk u_chk (.*);

/* tb/pulse_source.sv */
// pulse source on the length, count and length-reset terminals
// pins idle low and move only on falling edges of mclk
module pulse_source (
  input  wire logic mclk,
  output logic      high_speed_pulse_input,
  output logic      count_pulse_input,
  output logic      length_reset_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    high_speed_pulse_input = 1'b0;
    count_pulse_input = 1'b0;
    length_reset_input = 1'b0;
  end
  // n pulses, w cycles high and w+1 low between pulses, w at least 3
  task automatic pulses(input bit cnt, input int n, input int w);
    repeat (n) begin
      @(negedge mclk);
      if (cnt) count_pulse_input = 1'b1;
      else high_speed_pulse_input = 1'b1;
      repeat (w) @(negedge mclk);
      count_pulse_input = 1'b0;
      high_speed_pulse_input = 1'b0;
      repeat (w) @(negedge mclk);
    end
  endtask
  task automatic clear_len(input int w);
    @(negedge mclk);
    length_reset_input = 1'b1;
    repeat (w) @(negedge mclk);
    length_reset_input = 1'b0;
  endtask
endmodule

/* tb/swing_freq_length_counter_tb_top.sv */
// self-checking bench for swing_freq_length_counter
// settings change at falling edges, pulse_source drives the terminals
module swing_freq_length_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst_n = 1'b0, swing_base_select = 1'b0;
  logic [9:0]  swing_amplitude_pct = 10'h0, jump_amplitude_pct = 10'h0;
  logic [9:0]  rise_time_coefficient = 10'hFA;
  logic [14:0] swing_cycle_period = 15'h1;
  logic [15:0] centre_frequency_source = 16'h1388;
  logic [15:0] max_output_frequency = 16'h1770, upper_freq_limit = 16'hFFFF;
  logic [15:0] lower_freq_limit = 16'h0, target_length = 16'h3;
  logic [15:0] pulses_per_metre = 16'hA, final_count_target = 16'h5;
  logic [15:0] intermediate_count_target = 16'h2;
  logic [15:0] output_frequency, actual_swing_amplitude, measured_length;
  logic [15:0] count_value, hi, lo, jd, ju;
  logic        high_speed_pulse_input, count_pulse_input, length_reset_input;
  logic        length_reached, final_count_reached, intermediate_count_reached;
  int          fail_count = 0, checked = 0, cyc = 0, up, dn, nj, nu;
  always #12.5 mclk = ~mclk;
  swing_freq_length_counter #(.STEP_DIV_P(4))
    u_swing_freq_length_counter (.*);
  pulse_source u_pulse_source (.*);
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic ok(input logic c, input string m);
    checked++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // one swing period: extremes, step counts and turnaround jumps
  task automatic watch();
    logic [15:0] p;
    hi = output_frequency;
    lo = hi;
    p = hi;
    up = 0;
    dn = 0;
    nj = 0;
    nu = 0;
    jd = 16'h0;
    ju = 16'h0;
    repeat (4000) begin
      @(negedge mclk);
      if (output_frequency > hi) hi = output_frequency;
      if (output_frequency < lo) lo = output_frequency;
      if (output_frequency > p) up++;
      if (output_frequency < p) dn++;
      if (output_frequency > p && output_frequency - p > 16'h14) begin
        nu++;
        ju = output_frequency - p;
      end
      if (output_frequency < p && p - output_frequency > 16'h14) begin
        nj++;
        jd = p - output_frequency;
      end
      p = output_frequency;
    end
  endtask
  task automatic t_swing();
    swing_amplitude_pct = 10'h64;
    jump_amplitude_pct = 10'h64;
    w(8);
    ok(actual_swing_amplitude === 16'h1F4, "amp centre");
    swing_base_select = 1'b1;
    w(8);
    ok(actual_swing_amplitude === 16'h258, "amp max");
    swing_base_select = 1'b0;
    w(8);
    watch();
    ok(hi > 16'h1388 && lo < 16'h1388, "no swing");
    ok(hi >= 16'h1574 && hi <= 16'h157C, "top");
    ok(lo >= 16'h1194 && lo <= 16'h1198, "bottom");
    ok(nj == 1 && nu == 1, "one period");
    ok(jd >= 16'h28 && jd <= 16'h32, "top jump");
    ok(ju >= 16'h28 && ju <= 16'h32, "bottom jump");
    ok(up > 245 && up < 255, "rise steps");
    ok(dn > 745 && dn < 755, "fall steps");
    upper_freq_limit = 16'h1450;
    lower_freq_limit = 16'h1324;
    w(4);
    watch();
    ok(hi === 16'h1450 && lo === 16'h1324, "clamp");
    upper_freq_limit = 16'hFFFF;
    lower_freq_limit = 16'h0;
    swing_amplitude_pct = 10'h0;
    w(8);
    ok(output_frequency === 16'h1388, "centre");
  endtask
  task automatic t_length();
    u_pulse_source.pulses(1'b0, 3, 4);
    w(8);
    ok(measured_length === 16'h3 && length_reached === 1'b0, "eq");
    u_pulse_source.pulses(1'b0, 1, 8);
    w(8);
    ok(measured_length === 16'h4 && length_reached === 1'b1, "gt");
    pulses_per_metre = 16'h14;
    w(4);
    ok(measured_length === 16'h2, "per metre");
    u_pulse_source.clear_len(8);
    w(4);
    ok(measured_length === 16'h0 && length_reached === 1'b0, "clr");
  endtask
  task automatic t_count();
    u_pulse_source.pulses(1'b1, 1, 4);
    w(8);
    ok(count_value === 16'h1
       && intermediate_count_reached === 1'b0, "c1");
    u_pulse_source.pulses(1'b1, 1, 4);
    w(8);
    ok(intermediate_count_reached === 1'b1, "mid");
    ok(final_count_reached === 1'b0, "early");
    u_pulse_source.pulses(1'b1, 3, 4);
    w(8);
    ok(count_value === 16'h5 && final_count_reached === 1'b1, "fin");
    u_pulse_source.pulses(1'b1, 2, 8);
    w(8);
    ok(count_value === 16'h5, "stop");
  endtask
  task automatic t_reset();
    pulses_per_metre = 16'hA;
    u_pulse_source.pulses(1'b0, 4, 4);
    w(8);
    ok(measured_length === 16'h4 && length_reached === 1'b1, "pre");
    rst_n = 1'b0;
    w(4);
    ok(count_value === 16'h0 && measured_length === 16'h0, "acc");
    ok(length_reached === 1'b0, "len rst");
    ok(final_count_reached === 1'b0, "fin rst");
    ok(intermediate_count_reached === 1'b0, "mid rst");
    rst_n = 1'b1;
    w(2);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    w(10);
    rst_n = 1'b1;
    w(2);
    t_swing();
    t_length();
    t_count();
    t_reset();
    test_done();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
endmodule
